/* File: sfic_ctrl.sv */
// How it works
// - With no scaled data ready, the programmed blank fill byte goes out in active video.
// - Frame status updates when pixel counter reaches the 10-bit end pixel count.
// - Blank timing bit 0 gives no timing on blank fields; 1 gives unscaled H/V/F.
// - Field count sets how many output fields form the interleave sequence.
// - Sixteen 2-bit field modes over two registers, entry 0 in lowest bit pair.
// - Sequence counter steps entry 0 up to entry n, n 0..15, then wraps.
// - Mode 00 unscaled, 01 null without SAV/EAV, 10 scaled, 11 reserved.
// - Vertical accumulator loads 9-bit first-field initial value at field 1 start.
// - Vertical accumulator loads separate second-field initial value at field 2 start.
// - Output pixel count register, 10 bits, resets to 720 pixels per line.
// - One enable bit turns both scalers on or off; resets off.
// - Vertical coefficient is 9-bit ratio times 256; register resets to 2100h.
// - Horizontal step is 15-bit 5.10 fixed point; resets to unity 400h.
// - All these registers are 16 bits, reached through indirect access.
`timescale 1ns/1ps
`default_nettype none
`include "sfic_params.svh"

module sfic_ctrl (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [11:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    output logic [15:0] reg_rdata,
    input wire logic [6:0] clk_mode_in,
    input wire logic clk_mode_upd,
    input wire logic field_start,
    input wire logic field_odd,
    input wire logic active_video,
    input wire logic pixel_tick,
    input wire logic unscaled_timing,
    input wire logic [7:0] scaled_data,
    input wire logic scaled_valid,
    output logic scaled_ready,
    input wire logic [7:0] unscaled_data,
    output logic [7:0] out_data,
    output logic out_timing,
    output logic out_codes_en,
    output logic [1:0] cur_mode,
    output logic [3:0] seq_index,
    output logic frame_status,
    output logic scaler_enable,
    output logic [8:0] vertical_ratio_coefficient,
    output logic [14:0] horizontal_step_coefficient,
    output logic [9:0] output_pixels_per_line,
    output logic [8:0] vert_accum
);
    typedef struct packed {
        logic [15:0] misc;
        logic [15:0] seq;
        logic [15:0] modes_lo;
        logic [15:0] modes_hi;
        logic [15:0] vinit1;
        logic [15:0] vinit2;
        logic [15:0] outpix;
        logic [15:0] vctrl;
        logic [15:0] hctrl;
        logic [15:0] rdata;
        logic [3:0] idx;
        logic [9:0] pix;
        logic [8:0] vacc;
        logic fstat;
        logic [7:0] dout;
        logic timing;
        logic codes;
        sfic_pkg::sfic_state_type st;
    } sfic_state_type;

    sfic_state_type s_q, s_d;
    logic [31:0] modes_all;
    logic [1:0] mode_now;
    logic [7:0] fifo_data;
    logic fifo_valid;
    logic fifo_pop;

    // Pick a 2-bit mode entry from the packed 32-bit table
    function automatic logic [1:0] sfic_pick_mode(input logic [31:0] tbl, input logic [3:0] i);
        logic [4:0] b;
        b = {i, 1'b0};
        return tbl[b +: 2];
    endfunction

    // Next index with wrap after the last configured entry
    function automatic logic [3:0] sfic_next_idx(input logic [3:0] i, input logic [3:0] last);
        return (i >= last) ? 4'h0 : i + 4'h1;
    endfunction

    // ==========================================================
    // Scaled data buffer
    // Back-pressure stalls the scaler when the output is not taking scaled pixels
    sfic_fifo #(
        .WIDTH(`SFIC_FIFO_WIDTH),
        .DEPTH(`SFIC_FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .rst_n(rst_n),
        .in_data(scaled_data),
        .in_valid(scaled_valid),
        .in_ready(scaled_ready),
        .out_data(fifo_data),
        .out_valid(fifo_valid),
        .out_ready(fifo_pop)
    );

    assign modes_all = {s_q.modes_hi, s_q.modes_lo};
    assign mode_now = sfic_pick_mode(modes_all, s_q.idx);
    // Drain only in scaled fields during active video
    assign fifo_pop = pixel_tick && active_video && (mode_now == `SFIC_MODE_SCALED);

    // ==========================================================
    // Register file and field sequencing
    always_comb begin
        s_d = s_q;
        // Register writes, reserved bits forced to zero
        if (reg_wr) begin
            case (reg_addr)
                `SFIC_ADDR_MISC: s_d.misc = reg_wdata & `SFIC_MASK_MISC;
                `SFIC_ADDR_SEQ: s_d.seq = reg_wdata & `SFIC_MASK_SEQ;
                `SFIC_ADDR_MODES_LO: s_d.modes_lo = reg_wdata;
                `SFIC_ADDR_MODES_HI: s_d.modes_hi = reg_wdata;
                `SFIC_ADDR_VINIT1: s_d.vinit1 = reg_wdata & `SFIC_MASK_VINIT;
                `SFIC_ADDR_VINIT2: s_d.vinit2 = reg_wdata & `SFIC_MASK_VINIT;
                `SFIC_ADDR_OUTPIX: s_d.outpix = reg_wdata & `SFIC_MASK_OUTPIX;
                `SFIC_ADDR_VCTRL: s_d.vctrl = reg_wdata & `SFIC_MASK_VCTRL;
                `SFIC_ADDR_HCTRL: s_d.hctrl = reg_wdata & `SFIC_MASK_HCTRL;
                default: s_d.misc = s_q.misc;
            endcase
        end
        // Device owns the clock fields; its update wins over a host write
        if (clk_mode_upd) begin
            s_d.misc[`SFIC_MISC_CLK_MSB:`SFIC_MISC_CLK_LSB] = clk_mode_in;
        end
        // Read data latched one cycle after the strobe; unmapped reads zero
        if (reg_rd) begin
            case (reg_addr)
                `SFIC_ADDR_MISC: s_d.rdata = s_q.misc;
                `SFIC_ADDR_SEQ: s_d.rdata = s_q.seq;
                `SFIC_ADDR_MODES_LO: s_d.rdata = s_q.modes_lo;
                `SFIC_ADDR_MODES_HI: s_d.rdata = s_q.modes_hi;
                `SFIC_ADDR_VINIT1: s_d.rdata = s_q.vinit1;
                `SFIC_ADDR_VINIT2: s_d.rdata = s_q.vinit2;
                `SFIC_ADDR_OUTPIX: s_d.rdata = s_q.outpix;
                `SFIC_ADDR_VCTRL: s_d.rdata = s_q.vctrl;
                `SFIC_ADDR_HCTRL: s_d.rdata = s_q.hctrl;
                default: s_d.rdata = 16'h0000;
            endcase
        end

        // Field boundary: step sequence and reload the accumulator
        if (field_start) begin
            s_d.idx = sfic_next_idx(s_q.idx, s_q.seq[`SFIC_SEQ_COUNT_MSB:`SFIC_SEQ_COUNT_LSB]);
            s_d.pix = 10'h000;
            s_d.fstat = 1'b0;
            // Field 1 vs field 2 initial weight
            if (field_odd) begin
                s_d.vacc = s_q.vinit1[`SFIC_VINIT_MSB:0];
            end else begin
                s_d.vacc = s_q.vinit2[`SFIC_VINIT_MSB:0];
            end
        end else if (pixel_tick) begin
            // Field start clear wins over status set; counter holds once the end count is reached
            if (s_q.pix == s_q.seq[`SFIC_SEQ_END_MSB:0]) begin
                s_d.fstat = 1'b1;
            end else begin
                s_d.pix = s_q.pix + 10'h001;
            end
        end

        // Output state by mode of the current field
        case (s_q.st)
            sfic_pkg::SFIC_ST_IDLE: begin
                s_d.st = field_start ? sfic_pkg::SFIC_ST_ACTIVE : sfic_pkg::SFIC_ST_IDLE;
            end
            sfic_pkg::SFIC_ST_ACTIVE: begin
                s_d.st = (mode_now == `SFIC_MODE_NULL) ? sfic_pkg::SFIC_ST_BLANK
                                                      : sfic_pkg::SFIC_ST_ACTIVE;
            end
            sfic_pkg::SFIC_ST_BLANK: begin
                s_d.st = field_start ? sfic_pkg::SFIC_ST_ACTIVE : sfic_pkg::SFIC_ST_BLANK;
            end
            default: begin
                s_d.st = sfic_pkg::SFIC_ST_IDLE;
            end
        endcase

        // Data and timing per mode; reserved mode treated as null
        case (mode_now)
            `SFIC_MODE_UNSCALED: begin
                s_d.dout = unscaled_data;
                s_d.timing = unscaled_timing;
                s_d.codes = 1'b1;
            end
            `SFIC_MODE_SCALED: begin
                // Underflow falls back to the fill byte
                s_d.dout = (fifo_valid && active_video) ? fifo_data
                         : s_q.misc[`SFIC_MISC_FILL_MSB:`SFIC_MISC_FILL_LSB];
                s_d.timing = unscaled_timing;
                s_d.codes = 1'b1;
            end
            default: begin
                s_d.dout = s_q.misc[`SFIC_MISC_FILL_MSB:`SFIC_MISC_FILL_LSB];
                s_d.timing = s_q.seq[`SFIC_SEQ_BLANK_BIT] && unscaled_timing;
                s_d.codes = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q.misc <= `SFIC_RST_MISC;
            s_q.seq <= `SFIC_RST_SEQ;
            s_q.modes_lo <= `SFIC_RST_MODES;
            s_q.modes_hi <= `SFIC_RST_MODES;
            s_q.vinit1 <= `SFIC_RST_VINIT;
            s_q.vinit2 <= `SFIC_RST_VINIT;
            s_q.outpix <= `SFIC_RST_OUTPIX;
            s_q.vctrl <= `SFIC_RST_VCTRL;
            s_q.hctrl <= `SFIC_RST_HCTRL;
            s_q.rdata <= 16'h0000;
            s_q.idx <= 4'h0;
            s_q.pix <= 10'h000;
            s_q.vacc <= 9'h000;
            s_q.fstat <= 1'b0;
            s_q.dout <= 8'h00;
            s_q.timing <= 1'b0;
            s_q.codes <= 1'b0;
            s_q.st <= sfic_pkg::SFIC_ST_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

    // ==========================================================
    // Outputs
    assign reg_rdata = s_q.rdata;
    assign out_data = s_q.dout;
    assign out_timing = s_q.timing;
    assign out_codes_en = s_q.codes;
    assign cur_mode = mode_now;
    assign seq_index = s_q.idx;
    assign frame_status = s_q.fstat;
    assign scaler_enable = s_q.vctrl[`SFIC_VCTRL_EN_BIT];
    assign vertical_ratio_coefficient = s_q.vctrl[`SFIC_VCTRL_COEF_MSB:0];
    assign horizontal_step_coefficient = s_q.hctrl[`SFIC_HCTRL_COEF_MSB:0];
    assign output_pixels_per_line = s_q.outpix[`SFIC_OUTPIX_MSB:0];
    assign vert_accum = s_q.vacc;
endmodule

`default_nettype wire

/* File: sfic_params.svh */
`ifndef SFIC_PARAMS_SVH
`define SFIC_PARAMS_SVH

// ==========================================================
// Register indices (indirect address space)
`define SFIC_ADDR_MISC 12'h36B
`define SFIC_ADDR_SEQ 12'h36D
`define SFIC_ADDR_MODES_LO 12'h36E
`define SFIC_ADDR_MODES_HI 12'h36F
`define SFIC_ADDR_VINIT1 12'h3A8
`define SFIC_ADDR_VINIT2 12'h3A9
`define SFIC_ADDR_OUTPIX 12'h3AB
`define SFIC_ADDR_VCTRL 12'h3AC
`define SFIC_ADDR_HCTRL 12'h3AD

// ==========================================================
// Reset values
`define SFIC_RST_MISC 16'h000C
`define SFIC_RST_SEQ 16'h0000
`define SFIC_RST_MODES 16'h0000
`define SFIC_RST_VINIT 16'h0000
`define SFIC_RST_OUTPIX 16'h02D0
`define SFIC_RST_VCTRL 16'h2100
`define SFIC_RST_HCTRL 16'h0400

// ==========================================================
// Field positions
`define SFIC_MISC_CLK_LSB 0
`define SFIC_MISC_CLK_MSB 6
`define SFIC_MISC_FILL_LSB 8
`define SFIC_MISC_FILL_MSB 15
`define SFIC_SEQ_END_MSB 9
`define SFIC_SEQ_BLANK_BIT 10
`define SFIC_SEQ_COUNT_LSB 12
`define SFIC_SEQ_COUNT_MSB 15
`define SFIC_VINIT_MSB 8
`define SFIC_OUTPIX_MSB 9
`define SFIC_VCTRL_COEF_MSB 8
`define SFIC_VCTRL_EN_BIT 12
`define SFIC_HCTRL_COEF_MSB 14

// Writable bit masks (reserved bits read zero)
`define SFIC_MASK_MISC 16'hFF7F
`define SFIC_MASK_SEQ 16'hF7FF
`define SFIC_MASK_VINIT 16'h01FF
`define SFIC_MASK_OUTPIX 16'h03FF
`define SFIC_MASK_VCTRL 16'h11FF
`define SFIC_MASK_HCTRL 16'h7FFF

// Field mode codes
`define SFIC_MODE_UNSCALED 2'h0
`define SFIC_MODE_NULL 2'h1
`define SFIC_MODE_SCALED 2'h2

`define SFIC_FIFO_DEPTH 8
`define SFIC_FIFO_WIDTH 8

`endif

/* File: sfic_pkg.sv */
package sfic_pkg;
    typedef enum logic [1:0] {
        SFIC_UNSCALED = 2'h0,
        SFIC_NULL = 2'h1,
        SFIC_SCALED = 2'h2,
        SFIC_RSVD = 2'h3
    } sfic_mode_type;

    typedef enum logic [2:0] {
        SFIC_ST_IDLE = 3'h1,
        SFIC_ST_ACTIVE = 3'h2,
        SFIC_ST_BLANK = 3'h4
    } sfic_state_type;
endpackage

/* File: sfic_fifo.sv */
`timescale 1ns/1ps
`default_nettype none
`include "sfic_params.svh"

module sfic_fifo #(
    parameter int WIDTH = `SFIC_FIFO_WIDTH,
    parameter int DEPTH = `SFIC_FIFO_DEPTH
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
    } sfic_fifo_state_type;

    sfic_fifo_state_type s_q, s_d;
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic push;
    logic pop;

    // ==========================================================
    // Handshake
    assign in_ready = (s_q.cnt != DEPTH[AW:0]);
    assign out_valid = (s_q.cnt != '0);
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem_q[s_q.rp];

    // Pointer and count update
    always_comb begin
        s_d = s_q;
        if (push) begin
            s_d.wp = s_q.wp + 1'b1;
        end
        if (pop) begin
            s_d.rp = s_q.rp + 1'b1;
        end
        if (push && !pop) begin
            s_d.cnt = s_q.cnt + 1'b1;
        end else if (pop && !push) begin
            s_d.cnt = s_q.cnt - 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // Storage has no reset; only pointers and count need a defined value
    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[s_q.wp] <= in_data;
        end
    end
endmodule

`default_nettype wire

/* File: sfic_ctrl_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
`include "sfic_params.svh"

// ==========================================================
// Port-level checks of the control block
module sfic_ctrl_monitor (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [11:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic [15:0] reg_rdata,
    input wire logic field_start,
    input wire logic field_odd,
    input wire logic [1:0] cur_mode,
    input wire logic [3:0] seq_index,
    input wire logic out_codes_en,
    input wire logic frame_status,
    input wire logic scaler_enable,
    input wire logic [8:0] vertical_ratio_coefficient,
    input wire logic [14:0] horizontal_step_coefficient,
    input wire logic [9:0] output_pixels_per_line,
    input wire logic [8:0] vert_accum
);
    logic [15:0] wd_q;
    logic [3:0] cnt_q;
    logic [8:0] vi1_q;
    logic [8:0] vi2_q;

    // Shadows of the registers, since the checker cannot see inside
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wd_q <= 16'h0000;
            cnt_q <= 4'h0;
            vi1_q <= 9'h000;
            vi2_q <= 9'h000;
        end else begin
            wd_q <= reg_wdata;
            if (reg_wr && reg_addr == `SFIC_ADDR_SEQ) cnt_q <= reg_wdata[15:12];
            if (reg_wr && reg_addr == `SFIC_ADDR_VINIT1) vi1_q <= reg_wdata[8:0];
            if (reg_wr && reg_addr == `SFIC_ADDR_VINIT2) vi2_q <= reg_wdata[8:0];
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // ==========================================================
    // Assertions
    a_rdata_hold: assert property (!$past(reg_rd) |-> $stable(reg_rdata))
        else $error("read data moved without a read");
    a_enable_write: assert property (reg_wr && reg_addr == `SFIC_ADDR_VCTRL
        |=> scaler_enable == wd_q[12]) else $error("enable not taken");
    a_vcoef_write: assert property (reg_wr && reg_addr == `SFIC_ADDR_VCTRL
        |=> vertical_ratio_coefficient == wd_q[8:0]) else $error("vertical coef wrong");
    a_hcoef_write: assert property (reg_wr && reg_addr == `SFIC_ADDR_HCTRL
        |=> horizontal_step_coefficient == wd_q[14:0]) else $error("horizontal step wrong");
    a_pixels_write: assert property (reg_wr && reg_addr == `SFIC_ADDR_OUTPIX
        |=> output_pixels_per_line == wd_q[9:0]) else $error("pixel count wrong");
    a_seq_step: assert property (field_start |=> seq_index ==
        (($past(seq_index) >= cnt_q) ? 4'h0 : $past(seq_index) + 4'h1))
        else $error("sequence index step wrong");
    a_accum_first: assert property (field_start && field_odd |=> vert_accum == vi1_q)
        else $error("first field init wrong");
    a_accum_second: assert property (field_start && !field_odd |=> vert_accum == vi2_q)
        else $error("second field init wrong");
    a_null_codes: assert property (cur_mode == 2'h1 ##1 cur_mode == 2'h1 |-> !out_codes_en)
        else $error("codes in null field");
    a_status_clear: assert property (field_start |=> !frame_status)
        else $error("frame status not cleared");
endmodule

bind sfic_ctrl sfic_ctrl_monitor sfic_ctrl_monitor_i (.*);
`default_nettype wire

/* File: sfic_backend_model.sv */
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Back end receiver: takes one byte per active pixel, never stalls
module sfic_backend_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic pixel_tick,
    input wire logic active_video,
    input wire logic [7:0] out_data,
    output logic [7:0] last_byte
);
    logic tick_q;

    // Output byte lags the tick by one cycle, so capture a cycle late
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tick_q <= 1'b0;
            last_byte <= 8'h00;
        end else begin
            tick_q <= pixel_tick && active_video;
            if (tick_q) last_byte <= out_data;
        end
    end
endmodule
`default_nettype wire

/* File: sfic_ctrl_tb.sv */
`timescale 1ns/1ps
`default_nettype none

module sfic_ctrl_tb;
    logic clk, rst_n, reg_wr, reg_rd, clk_mode_upd, field_start, field_odd, active_video;
    logic pixel_tick, unscaled_timing, scaled_valid, scaled_ready, out_timing, out_codes_en;
    logic frame_status, scaler_enable, seen;
    logic [11:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata;
    logic [6:0] clk_mode_in;
    logic [7:0] scaled_data, unscaled_data, out_data, last_byte;
    logic [1:0] cur_mode;
    logic [3:0] seq_index, idx, cnt;
    logic [8:0] vertical_ratio_coefficient, vert_accum, v1, v2;
    logic [14:0] horizontal_step_coefficient;
    logic [9:0] output_pixels_per_line;
    logic [31:0] modes;
    int fails, tests_run, n;
    logic [11:0] ad [9] = '{12'h36B, 12'h36D, 12'h36E, 12'h36F, 12'h3A8, 12'h3A9,
        12'h3AB, 12'h3AC, 12'h3AD};
    logic [15:0] rv [9] = '{16'h000C, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
        16'h02D0, 16'h2100, 16'h0400};
    logic [15:0] mk [9] = '{16'hFF7F, 16'hF7FF, 16'hFFFF, 16'hFFFF, 16'h01FF, 16'h01FF,
        16'h03FF, 16'h11FF, 16'h7FFF};

    sfic_ctrl sfic_ctrl_i (.*);
    sfic_backend_model sfic_backend_model_i (.*);

    // 100 MHz clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // ==========================================================
    // Access and compare tasks
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    // Read data is registered at the edge that takes the strobe
    task automatic rd(input logic [11:0] a, input logic [15:0] exp);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 chk("read data", exp, reg_rdata);
    endtask

    task automatic fld(input logic odd);
        @(posedge clk);
        field_start <= 1'b1;
        field_odd <= odd;
        @(posedge clk);
        field_start <= 1'b0;
        idx = (idx >= cnt) ? 4'h0 : idx + 4'h1;
        #1 chk("sequence index", 16'(idx), 16'(seq_index));
        chk("field mode", 16'(modes[2*idx +: 2]), 16'(cur_mode));
        chk("accum init", 16'(odd ? v1 : v2), 16'(vert_accum));
    endtask

    task automatic tick(input logic [7:0] exp);
        @(posedge clk);
        pixel_tick <= 1'b1;
        @(posedge clk);
        pixel_tick <= 1'b0;
        #1 chk("output byte", 16'(exp), 16'(out_data));
    endtask

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        {rst_n, reg_wr, reg_rd, clk_mode_upd, field_start, field_odd} = '0;
        {active_video, pixel_tick, unscaled_timing, scaled_valid} = '0;
        {reg_addr, reg_wdata, clk_mode_in, scaled_data, unscaled_data} = '0;
        {fails, tests_run, idx, cnt, modes, v1, v2} = '0;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 9; i++) rd(ad[i], rv[i]);
        chk("enable", 16'h0000, 16'(scaler_enable));
        chk("vertical_ratio_coefficient", 16'h0100, 16'(vertical_ratio_coefficient));
        chk("horizontal_step_coefficient", 16'h0400, 16'(horizontal_step_coefficient));
        $display("test reset values done");
        // All ones: reserved bits must read back zero
        for (int i = 0; i < 9; i++) begin
            wr(ad[i], 16'hFFFF);
            rd(ad[i], mk[i]);
        end
        wr(12'h3AA, 16'hFFFF);
        rd(12'h3AA, 16'h0000);
        chk("enable", 16'h0001, 16'(scaler_enable));
        chk("vertical_ratio_coefficient", 16'h01FF, 16'(vertical_ratio_coefficient));
        chk("horizontal_step_coefficient", 16'h7FFF, 16'(horizontal_step_coefficient));
        chk("pixels", 16'h03FF, 16'(output_pixels_per_line));
        $display("test masks done");
        // Device clock update lands in the same cycle as a host write
        @(posedge clk);
        {clk_mode_upd, reg_wr} <= 2'h3;
        clk_mode_in <= 7'h55;
        reg_addr <= 12'h36B;
        reg_wdata <= 16'h5A00;
        @(posedge clk);
        {clk_mode_upd, reg_wr} <= 2'h0;
        rd(12'h36B, 16'h5A55);
        $display("test clock update done");
        // Count 3, blank timing on, end count 5; entries 00 10 01 11, entry 15 scaled
        wr(12'h36D, 16'h3405);
        wr(12'h36E, 16'h00D8);
        wr(12'h36F, 16'h8000);
        // Host-side init values for a 0.75 ratio: second 192, first 1.5 x 192 - 128
        wr(12'h3A8, 16'h00A0);
        wr(12'h3A9, 16'h00C0);
        {cnt, v1, v2, modes} = {4'h3, 9'h0A0, 9'h0C0, 32'h800000D8};
        for (int i = 0; i < 6; i++) fld(i[0]);
        active_video <= 1'b1;
        unscaled_timing <= 1'b1;
        unscaled_data <= 8'h3C;
        tick(8'h5A);
        chk("codes", 16'h0000, 16'(out_codes_en));
        chk("timing", 16'h0001, 16'(out_timing));
        wr(12'h36D, 16'h3005);
        tick(8'h5A);
        chk("timing", 16'h0000, 16'(out_timing));
        fld(1'b1);
        fld(1'b0);
        tick(8'h3C);
        // Ticks every cycle until the end count is passed
        seen = 1'b0;
        @(posedge clk);
        pixel_tick <= 1'b1;
        repeat (8) begin
            @(posedge clk);
            #1 seen = seen | frame_status;
        end
        pixel_tick <= 1'b0;
        chk("frame status", 16'h0001, 16'(seen));
        $display("test fields done");
        // Fill the buffer with no pops until it refuses
        active_video <= 1'b0;
        scaled_valid <= 1'b1;
        scaled_data <= 8'hA0;
        n = 0;
        repeat (12) begin
            @(negedge clk);
            seen = scaled_ready;
            @(posedge clk);
            if (seen === 1'b1) n++;
            scaled_data <= 8'(8'hA0 + n);
        end
        scaled_valid <= 1'b0;
        chk("buffer depth", 16'h0008, 16'(n));
        fld(1'b1);
        active_video <= 1'b1;
        for (int i = 0; i < 8; i++) tick(8'(8'hA0 + i));
        tick(8'h5A);
        @(posedge clk);
        #1 chk("partner byte", 16'h005A, 16'(last_byte));
        $display("test scaled stream done");
        // Longest sequence: sixteen entries then wrap
        wr(12'h36D, 16'hF000);
        cnt = 4'hF;
        for (int i = 0; i < 16; i++) fld(i[0]);
        $display("test wrap done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
